// ### core/mct_pkg.sv
package mct_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h000;
    localparam logic [11:0] OFS_ENABLE_CTL = 12'h004;
    localparam logic [11:0] OFS_MAIN_COUNTER = 12'h008;
    localparam logic [11:0] OFS_PRESCALE_LIMIT = 12'h00C;
    localparam logic [11:0] OFS_PRESCALE_COUNT = 12'h010;
    localparam logic [11:0] OFS_MATCH_CTL = 12'h014;
    localparam logic [11:0] OFS_COMPARE0 = 12'h018;
    localparam logic [11:0] OFS_CAPTURE_CTL = 12'h028;
    localparam logic [11:0] OFS_CAPTURE0 = 12'h02C;
    localparam logic [11:0] OFS_CAPTURE1 = 12'h034;
    localparam logic [11:0] OFS_EXT_MATCH_CTL = 12'h03C;
    localparam logic [11:0] OFS_COUNT_CTL = 12'h070;
    localparam logic [11:0] OFS_PWM_MODE_CTL = 12'h074;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int ENA_BIT = 0;
    localparam int RST_BIT = 1;
    localparam int CAP_IRQ_POS = 4;
    localparam int MCTL_STRIDE = 3;
    localparam int CCTL_STRIDE = 3;
    localparam int EMC_POS = 4;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // counter source selection in the count control field
    typedef enum logic [1:0] {
        MCT_SRC_PCLK = 2'h0,
        MCT_SRC_RISE = 2'h1,
        MCT_SRC_FALL = 2'h2,
        MCT_SRC_BOTH = 2'h3
    } mct_src_t;
    // action on a match for a plain external match output
    typedef enum logic [1:0] {
        MCT_EM_NONE = 2'h0,
        MCT_EM_LOW = 2'h1,
        MCT_EM_HIGH = 2'h2,
        MCT_EM_TOGGLE = 2'h3
    } mct_em_t;
    // per-channel match control carrier
    typedef struct packed {
        logic stop;
        logic rst;
        logic intr;
    } mct_mctl_t;
endpackage

// ### core/mct_timer.sv
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Contract
// [RQ1] pwm outputs go low when the counter returns to zero, unless compare is zero
// [RQ2] pwm output goes high on its compare match; no match keeps it low
// [RQ3] compare raised above period while high: output clears at next period start
// [RQ4] compare equal to period gives a one tick wide high pulse each period
// [RQ5] compare zero: output goes high at first wrap and stays high
// [RQ6] software sets only reset-on-match for period channel, none for pwm channels
// [RQ7] reset-on-match clears counter at end of the prescaled cycle that matched
// [RQ8] match interrupt flag rises one clock after counter reaches compare value
// [RQ9] stop-on-match clears counter enable one clock after match, flag same clock
// [RQ10] 32-bit counter behind a 32-bit programmable prescaler
// [RQ11] selected capture edge copies counter into capture register, optional flag
// [RQ12] optional clear of counter and prescaler on a chosen capture edge
// [RQ13] four compare registers, each may run on, stop or reset, with flag
// [RQ14] each compare drives an output: low, high, toggle or nothing on match
// [RQ15] one compare sets the period, up to three others produce single-edge pwm
// [RQ16] a selected capture input may replace pclk as counting source
// [RQ17] output function chosen by external match control and pwm mode control
// [RQ18] counter steps every limit plus one events, prescaler clears on each step
// [RQ19] period reset clears every pwm output that is high, except one whose compare is zero
// [RQ20] all compares evaluated every clock, simultaneous matches act together
module mct_timer
    import mct_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic pclk, // peripheral clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [1:0] capture_inputs, // capture pins, asynchronous
    output logic [3:0] match_outputs, // match pins
    output logic match_irq // level, any pending status flag
);
    initial begin
        if (W != 32) $error("mct_timer supports only W = 32");
    end
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [5:0] flags_q;
    logic en_q, crst_q;
    logic [W-1:0] tc_q, pc_q, pr_q;
    logic [11:0] mctl_q;
    logic [W-1:0] mr_q [4];
    logic [5:0] cctl_q;
    logic [W-1:0] cr_q [2];
    logic [11:0] emr_q;
    logic [7:0] ctcr_q;
    logic [3:0] pwm_en_q, pwm_q;
    logic fresh_q;
    logic [31:0] prdata_q;
    logic err_q;
    logic [1:0] cs1_q, cs2_q, cs3_q;

    function automatic mct_mctl_t mctl_of(input logic [11:0] m, input int n);
        return mct_mctl_t'(m[n*MCTL_STRIDE +: MCTL_STRIDE]);
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic wr, setup;
    assign wr = psel && penable && pwrite;
    assign setup = psel && !penable;
    assign pready = psel && penable; // zero wait states
    assign prdata = prdata_q;
    assign pslverr = err_q && psel && penable;

    logic [31:0] rd_d;
    logic hit;
    // read mux; reserved bits above the used fields read as zero
    always_comb begin
        rd_d = RESET_WORD;
        hit = 1'b1;
        if (paddr == OFS_IRQ_STATUS) begin
            rd_d = {26'h0, flags_q};
        end else if (paddr == OFS_ENABLE_CTL) begin
            rd_d = {30'h0, crst_q, en_q};
        end else if (paddr == OFS_MAIN_COUNTER) begin
            rd_d = tc_q;
        end else if (paddr == OFS_PRESCALE_LIMIT) begin
            rd_d = pr_q;
        end else if (paddr == OFS_PRESCALE_COUNT) begin
            rd_d = pc_q;
        end else if (paddr == OFS_MATCH_CTL) begin
            rd_d = {20'h0, mctl_q};
        end else if (paddr >= OFS_COMPARE0 && paddr < OFS_CAPTURE_CTL && paddr[1:0] == 2'h0) begin
            rd_d = mr_q[paddr[3:2] - 2'h2];
        end else if (paddr == OFS_CAPTURE_CTL) begin
            rd_d = {26'h0, cctl_q};
        end else if (paddr == OFS_CAPTURE0) begin
            rd_d = cr_q[0];
        end else if (paddr == OFS_CAPTURE1) begin
            rd_d = cr_q[1];
        end else if (paddr == OFS_EXT_MATCH_CTL) begin
            rd_d = {20'h0, emr_q[11:4], match_outputs};
        end else if (paddr == OFS_COUNT_CTL) begin
            rd_d = {24'h0, ctcr_q};
        end else if (paddr == OFS_PWM_MODE_CTL) begin
            rd_d = {28'h0, pwm_en_q};
        end else begin
            hit = 1'b0;
        end
    end

    // read data and error are sampled in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RESET_WORD;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? RESET_WORD : rd_d;
            err_q <= !hit;
        end
    end

    // ------------------------------------------------------------
    // capture input synchronisers and edges
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs1_q <= 2'h0;
            cs2_q <= 2'h0;
            cs3_q <= 2'h0;
        end else begin
            cs1_q <= capture_inputs;
            cs2_q <= cs1_q;
            cs3_q <= cs2_q;
        end
    end
    logic [1:0] rise, fall;
    assign rise = cs2_q & ~cs3_q;
    assign fall = ~cs2_q & cs3_q;

    // ------------------------------------------------------------
    // count source, prescaler, counter
    // ------------------------------------------------------------
    mct_src_t src;
    logic sel_in, cnt_evt, tick, cap_clr, wrap, stop_now;
    logic [3:0] mlev, mevt, rst_en, stop_en;
    logic [1:0] cap_evt;
    assign src = mct_src_t'(ctcr_q[1:0]);
    assign sel_in = ctcr_q[2]; // only two inputs; upper select bit ignored
    // edges of the chosen pin stand in for pclk [RQ16]
    always_comb begin
        case (src)
            MCT_SRC_PCLK: cnt_evt = 1'b1;
            MCT_SRC_RISE: cnt_evt = rise[sel_in];
            MCT_SRC_FALL: cnt_evt = fall[sel_in];
            default: cnt_evt = rise[sel_in] | fall[sel_in];
        endcase
    end
    // a stopping match freezes the counter at the matched value, not one past it
    assign stop_now = |(mevt & stop_en); // [RQ9]
    assign tick = en_q && !crst_q && !stop_now && cnt_evt && (pc_q == pr_q); // [RQ18]
    // clear on the chosen capture edge, select values above 3 do nothing
    assign cap_clr = ctcr_q[4] && !ctcr_q[7] && (ctcr_q[5] ? fall[ctcr_q[6]] : rise[ctcr_q[6]]); // [RQ12]

    // every compare checked against the counter each clock [RQ20]
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            mlev[n] = (tc_q == mr_q[n]);
            rst_en[n] = mctl_of(mctl_q, n).rst;
            stop_en[n] = mctl_of(mctl_q, n).stop;
        end
    end
    // a match acts once, in the first clock the counter holds the value
    assign mevt = mlev & {4{fresh_q}};
    assign wrap = tick && |(mlev & rst_en); // period channel resets [RQ7] [RQ15]

    logic [W-1:0] tc_d;
    // counter next value: clear wins over step, software write wins over all
    always_comb begin
        tc_d = tc_q;
        if (wr && paddr == OFS_MAIN_COUNTER) begin
            tc_d = pwdata;
        end else if (crst_q || cap_clr) begin
            tc_d = '0;
        end else if (wrap) begin
            tc_d = '0; // [RQ7]
        end else if (tick) begin
            tc_d = tc_q + 1'b1; // [RQ10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_q <= '0;
            fresh_q <= 1'b1;
        end else begin
            tc_q <= tc_d;
            fresh_q <= (tc_d != tc_q);
        end
    end

    // prescale counter clears on each counter step [RQ18]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= '0;
        end else if (wr && paddr == OFS_PRESCALE_COUNT) begin
            pc_q <= pwdata;
        end else if (crst_q || cap_clr || tick) begin
            pc_q <= '0; // [RQ12]
        end else if (en_q && !stop_now && cnt_evt) begin
            pc_q <= pc_q + 1'b1; // [RQ9]
        end
    end

    // ------------------------------------------------------------
    // control and configuration registers
    // ------------------------------------------------------------
    // stop-on-match beats a software enable in the same clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            crst_q <= 1'b0;
        end else begin
            if (wr && paddr == OFS_ENABLE_CTL) begin
                en_q <= pwdata[ENA_BIT];
                crst_q <= pwdata[RST_BIT];
            end
            if (|(mevt & stop_en)) begin
                en_q <= 1'b0; // [RQ9] [RQ13]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pr_q <= '0;
            mctl_q <= 12'h000;
            cctl_q <= 6'h00;
            ctcr_q <= 8'h00;
            pwm_en_q <= 4'h0;
            for (int n = 0; n < 4; n++) begin
                mr_q[n] <= '0;
            end
        end else if (wr) begin
            if (paddr == OFS_PRESCALE_LIMIT) pr_q <= pwdata;
            if (paddr == OFS_MATCH_CTL) mctl_q <= pwdata[11:0];
            if (paddr == OFS_CAPTURE_CTL) cctl_q <= pwdata[5:0];
            if (paddr == OFS_COUNT_CTL) ctcr_q <= pwdata[7:0];
            if (paddr == OFS_PWM_MODE_CTL) pwm_en_q <= pwdata[3:0];
            for (int n = 0; n < 4; n++) begin
                if (paddr == OFS_COMPARE0 + 12'(4 * n)) mr_q[n] <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // capture registers and status flags
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            cap_evt[c] = (cctl_q[c*CCTL_STRIDE] & rise[c]) | (cctl_q[c*CCTL_STRIDE+1] & fall[c]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cr_q[0] <= '0;
            cr_q[1] <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (cap_evt[c]) cr_q[c] <= tc_q; // [RQ11]
            end
        end
    end

    logic [5:0] fset, fclr;
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            fset[n] = mevt[n] && mctl_of(mctl_q, n).intr; // [RQ8] [RQ13]
        end
        for (int c = 0; c < 2; c++) begin
            fset[CAP_IRQ_POS+c] = cap_evt[c] && cctl_q[c*CCTL_STRIDE+2]; // [RQ11]
        end
        fclr = (wr && paddr == OFS_IRQ_STATUS) ? pwdata[5:0] : 6'h00;
    end
    // write one to clear; a new event in the same clock stays set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) flags_q <= 6'h00;
        else flags_q <= (flags_q & ~fclr) | fset;
    end
    assign match_irq = |flags_q;

    // ------------------------------------------------------------
    // match outputs
    // ------------------------------------------------------------
    // plain outputs follow their match action; software may also write the level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emr_q <= 12'h000;
        end else begin
            if (wr && paddr == OFS_EXT_MATCH_CTL) emr_q <= pwdata[11:0];
            for (int n = 0; n < 4; n++) begin
                if (mevt[n]) begin
                    case (mct_em_t'(emr_q[EMC_POS+2*n +: 2])) // [RQ14]
                        MCT_EM_LOW: emr_q[n] <= 1'b0;
                        MCT_EM_HIGH: emr_q[n] <= 1'b1;
                        MCT_EM_TOGGLE: emr_q[n] <= ~emr_q[n];
                        default: emr_q[n] <= emr_q[n];
                    endcase
                end
            end
        end
    end

    // single-edge pwm: set as the counter is loaded with the compare value, so the
    // output is high in the very tick the counter holds it; cleared by the period reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_q <= 4'h0;
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (wrap) begin
                    pwm_q[n] <= (mr_q[n] == '0); // [RQ1] [RQ3] [RQ4] [RQ5] [RQ19]
                end else if (tc_d != tc_q && tc_d == mr_q[n]) begin
                    pwm_q[n] <= 1'b1; // [RQ2] [RQ4]
                end
            end
        end
    end
    assign match_outputs = (pwm_en_q & pwm_q) | (~pwm_en_q & emr_q[3:0]); // [RQ17]

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    match_flag_a: assert property (fset[0] |=> flags_q[0]) // [RQ8]
        else $error("match flag not raised one clock after match");
    stop_clear_a: assert property (mevt[2] && stop_en[2] |=> !en_q) // [RQ9]
        else $error("enable not cleared after stop match");
    wrap_zero_a: assert property (wrap && !wr |=> tc_q == '0) // [RQ7]
        else $error("counter not cleared at period end");
    presc_clear_a: assert property (tick && !wr |=> pc_q == '0) // [RQ18]
        else $error("prescaler not cleared on step");
    count_step_a: assert property (tick && !wrap && !cap_clr && !wr
        |=> tc_q == $past(tc_q) + 32'h1) // [RQ10]
        else $error("counter did not step by one");
    pwm_low_a: assert property (wrap && pwm_en_q[1] && mr_q[1] != '0 && !wr
        |=> !match_outputs[1]) // [RQ1]
        else $error("pwm output not low at period start");
    pwm_high_a: assert property (mevt[1] && !wrap && pwm_en_q[1] && !wr
        |=> match_outputs[1]) // [RQ2]
        else $error("pwm output not high after match");
    pwm_zero_a: assert property (wrap && pwm_en_q[2] && mr_q[2] == '0 && !wr
        |=> match_outputs[2]) // [RQ5]
        else $error("zero compare pwm not high after wrap");
    capture_val_a: assert property (cap_evt[0] |=> cr_q[0] == $past(tc_q)) // [RQ11]
        else $error("capture did not copy counter");

    wrap_seen_c: cover property (wrap ##1 tick);
    pwm_pulse_c: cover property (pwm_en_q[1] && mevt[1] ##[1:50] wrap);
    capture_c: cover property (cap_evt[1] && cap_clr);
endmodule

// ### testbench/mct_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// pin partner: drives capture pins, watches match pins
// ------------------------------------------------------------
module mct_pin_model (
    input wire logic clk, // timer clock
    output logic [1:0] cap, // capture pins into the timer
    input wire logic [3:0] mat // match pins out of the timer
);
    int hi[4];

    // pins idle low; a real source is always driven, no float here
    initial cap = 2'h0;

    // change one pin just after an edge and hold it until the next call
    task automatic set_pin(input int ch, input logic v);
        @(posedge clk);
        cap[ch] <= v;
    endtask

    // clocks at high level per match pin over a window of n clocks
    task automatic count_high(input int n);
        for (int i = 0; i < 4; i++) hi[i] = 0;
        repeat (n) begin
            @(posedge clk);
            for (int i = 0; i < 4; i++) hi[i] += int'(mat[i] === 1'b1);
        end
    endtask
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import mct_pkg::*;
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic err;
    } mct_row_t;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, match_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [1:0] cap;
    logic [3:0] mat;
    logic rerr;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    real t0;
    int pwm_exp[4] = '{60, 10, 100, 50};
    // writable fields read back, reserved bits read 0, unmapped gives an error
    mct_row_t rows[7] = '{
        '{OFS_PRESCALE_LIMIT, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0},
        '{OFS_COMPARE0 + 12'h004, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 1'b0},
        '{OFS_MATCH_CTL, 32'hFFFF_FFFF, 32'h0000_0FFF, 1'b0},
        '{OFS_PWM_MODE_CTL, 32'hFFFF_FFFF, 32'h0000_000F, 1'b0},
        '{OFS_CAPTURE_CTL, 32'h0000_003F, 32'h0000_003F, 1'b0},
        '{OFS_CAPTURE0, 32'h0000_1234, 32'h0000_0000, 1'b0},
        '{12'h030, 32'h0000_0001, 32'h0000_0000, 1'b1}};

    // ------------------------------------------------------------
    // clock, design and partner
    // ------------------------------------------------------------
    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    mct_timer #(.W(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_inputs(cap), .match_outputs(mat), .match_irq(match_irq));

    mct_pin_model pins (.clk(pclk), .cap(cap), .mat(mat));

    // ------------------------------------------------------------
    // bus tasks and comparisons
    // ------------------------------------------------------------
    // request held until the edge that sees pready; only the hang guard ends a wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // capture latency through the synchroniser may land one clock either way
    task automatic cmp_range(input logic [31:0] got, input logic [31:0] lo,
        input logic [31:0] hi);
        cmp_count++;
        if (!(got >= lo && got <= hi)) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    // always moves one edge first, but a flag still high from before ends the wait at that edge
    task automatic wait_irq();
        do begin
            @(posedge pclk);
        end while (match_irq !== 1'b1);
    endtask
    // hold counter in reset and drop old flags before a new setup
    task automatic park();
        wr(OFS_ENABLE_CTL, 32'h2);
        wr(OFS_IRQ_STATUS, 32'h3F);
    endtask
    task automatic final_report();
        $display("miscompares %0d, compares %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard, far beyond the several hundred clocks the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a);
            cmp32(rdat, 32'h0);
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            cmp32(rdat, rows[i].e);
            cmp32({31'h0, rerr}, {31'h0, rows[i].err});
        end
        // prescale 2, reset and flag on match 6: 7 values of 3 clocks
        park();
        wr(OFS_PWM_MODE_CTL, 32'h0);
        wr(OFS_CAPTURE_CTL, 32'h0);
        wr(OFS_PRESCALE_LIMIT, 32'h2);
        wr(OFS_COMPARE0, 32'h6);
        wr(OFS_MATCH_CTL, 32'h3);
        wr(OFS_ENABLE_CTL, 32'h1);
        wait_irq();
        t0 = $realtime;
        wr(OFS_IRQ_STATUS, 32'h1);
        wait_irq();
        cmp32(32'($rtoi(($realtime - t0) / 5.0)), 32'd21);
        // stop and flag on match 6, no prescale
        park();
        wr(OFS_PRESCALE_LIMIT, 32'h0);
        wr(OFS_MATCH_CTL, 32'h5);
        wr(OFS_ENABLE_CTL, 32'h1);
        wait_irq();
        rd(OFS_ENABLE_CTL);
        cmp32(rdat, 32'h0);
        rd(OFS_MAIN_COUNTER);
        cmp32(rdat, 32'h6);
        // period on channel 3 only, pwm on 0..2, channel 3 toggles
        park();
        wr(OFS_MATCH_CTL, 32'h400);
        wr(OFS_COMPARE0, 32'h4);
        wr(OFS_COMPARE0 + 12'h004, 32'h9);
        wr(OFS_COMPARE0 + 12'h008, 32'h0);
        wr(OFS_COMPARE0 + 12'h00C, 32'h9);
        wr(OFS_EXT_MATCH_CTL, 32'hC00);
        wr(OFS_PWM_MODE_CTL, 32'h7);
        wr(OFS_ENABLE_CTL, 32'h1);
        repeat (30) @(posedge pclk);
        pins.count_high(100);
        for (int i = 0; i < 4; i++) begin
            cmp32(32'(pins.hi[i]), 32'(pwm_exp[i]));
        end
        wr(OFS_COMPARE0, 32'd20);
        repeat (20) @(posedge pclk);
        pins.count_high(100);
        cmp32(32'(pins.hi[0]), 32'h0);
        // count rising edges of capture pin 0 instead of pclk
        park();
        wr(OFS_PWM_MODE_CTL, 32'h0);
        wr(OFS_MATCH_CTL, 32'h0);
        wr(OFS_COUNT_CTL, 32'h1);
        wr(OFS_ENABLE_CTL, 32'h1);
        repeat (5) begin
            pins.set_pin(0, 1'b1);
            repeat (4) @(posedge pclk);
            pins.set_pin(0, 1'b0);
            repeat (4) @(posedge pclk);
        end
        rd(OFS_MAIN_COUNTER);
        cmp32(rdat, 32'h5);
        // falling edge on pin 1 clears, rising edge on pin 0 captures
        park();
        wr(OFS_COUNT_CTL, 32'h70);
        wr(OFS_CAPTURE_CTL, 32'h5);
        wr(OFS_ENABLE_CTL, 32'h1);
        pins.set_pin(1, 1'b1);
        repeat (4) @(posedge pclk);
        pins.set_pin(1, 1'b0);
        repeat (39) @(posedge pclk);
        pins.set_pin(0, 1'b1);
        repeat (8) @(posedge pclk);
        rd(OFS_CAPTURE0);
        cmp_range(rdat, 32'd39, 32'd41);
        rd(OFS_IRQ_STATUS);
        cmp32(rdat & 32'h10, 32'h10);
        final_report();
    end
endmodule
